// ===== sim/crp_host.sv
// host model driving the control port
`timescale 1ns/10ps
module crp_host
   import crp_pkg::*;
(
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h55;
      reg_wdata = 16'hA5A5;
   end
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = (a == ADDR_POWER_ONE) ? (d & 16'h01FF) : d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // idle lines toggle so stale values are never trusted
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
endmodule

// ===== sim/crp_regs_asserts.sv
// concurrent checks on the ports of the reset and power register slice
`timescale 1ns/10ps
module crp_regs_chk
   import crp_pkg::*;
#(
   parameter logic [DATA_W-1:0] DEVICE_IDENTITY_CODE = 16'h0000,
   parameter logic [REVISION_W-1:0] DEVICE_REVISION = 3'h0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic output_amp_request,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_rd_valid,
   input wire logic reg_wr_ack,
   input wire logic reg_addr_miss,
   input wire logic soft_reset_strobe,
   input wire logic device_reset,
   input wire logic independent_bias_enable,
   input wire logic bias_generator_on,
   input wire logic level_shifter_enable,
   input wire logic aux_input_buffer_enable,
   input wire logic pll_power_enable,
   input wire logic mic_bias_enable,
   input wire logic mic_bias_drive_en,
   input wire logic amplifier_bias_enable,
   input wire logic output_amp_granted,
   input wire logic bias_order_fault
);
   logic [5:0] en6;
   assign en6 = {independent_bias_enable, level_shifter_enable, aux_input_buffer_enable,
      pll_power_enable, mic_bias_enable, amplifier_bias_enable};
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   a_soft_reset: assert property (reg_wr && reg_addr == 7'h00 && !device_reset |=>
      soft_reset_strobe && device_reset) else $error("soft reset not seen");
   a_strobe_pulse: assert property (soft_reset_strobe
      && !(reg_wr && reg_addr == 7'h00) |=> !soft_reset_strobe)
      else $error("reset strobe held");
   a_soft_clear: assert property (reg_wr && reg_addr == 7'h00 && !device_reset
      |=> ##1 en6 == 6'h00) else $error("enables survive soft reset");
   a_id_read: assert property (reg_rd && reg_addr == 7'h00 && !device_reset
      |=> reg_rd_valid && reg_rdata == DEVICE_IDENTITY_CODE) else $error("bad identity read");
   a_rev_read: assert property (reg_rd && reg_addr == 7'h01 && !device_reset
      |=> reg_rdata[2:0] == DEVICE_REVISION && reg_rdata[15:9] == 7'h00)
      else $error("bad revision read");
   a_wr_effect: assert property (reg_wr
      && reg_addr == 7'h01 && !device_reset |=> ##1 en6 == $past(reg_wdata[8:3], 2))
      else $error("enables differ from write");
   a_mic_hiz: assert property (mic_bias_drive_en == mic_bias_enable)
      else $error("mic bias drive mismatch");
   a_addr_miss: assert property ((reg_wr || reg_rd) && reg_addr > 7'h01 && !device_reset
      |=> reg_addr_miss) else $error("unmapped access not flagged");
   a_wr_ack: assert property (reg_wr && !device_reset |=> reg_wr_ack)
      else $error("write not acknowledged");
   a_bias_gen: assert property (independent_bias_enable |-> bias_generator_on)
      else $error("bias generator off");
   a_amp_grant: assert property (!device_reset && output_amp_request ##1
      independent_bias_enable |-> output_amp_granted) else $error("amp not granted");
   a_order_fault: assert property (!device_reset && output_amp_request ##1
      !bias_generator_on |-> bias_order_fault && !output_amp_granted)
      else $error("order fault missed");
endmodule

bind crp_regs crp_regs_chk #(.DEVICE_IDENTITY_CODE(DEVICE_IDENTITY_CODE),
   .DEVICE_REVISION(DEVICE_REVISION)) chk (.*);

// ===== sim/tb.sv
// self-checking bench for the reset and power register slice
`timescale 1ns/10ps
module tb
   import crp_pkg::*;
;
   localparam logic [DATA_W-1:0] ID = 16'hC3A5; // arbitrary value
   localparam logic [2:0] REV = 3'h5; // arbitrary value
   logic clk, rst, power_on_n, mid_rail_reference_ready, reference_buffer_ready;
   logic output_amp_request, reg_wr, reg_rd, reg_rd_valid, reg_wr_ack, reg_addr_miss;
   logic soft_reset_strobe, device_reset, independent_bias_enable, bias_generator_on;
   logic level_shifter_enable, aux_input_buffer_enable, pll_power_enable, mic_bias_enable;
   logic mic_bias_drive_en, amplifier_bias_enable, output_amp_granted, bias_order_fault;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic [DATA_W-1:0] exp_q[$];
   int errors, checked;
   crp_regs #(.DEVICE_IDENTITY_CODE(ID), .DEVICE_REVISION(REV), .HOLD_CYCLES(2)) uut (.*);
   crp_host host (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [15:0] en6();
      return {10'h000, independent_bias_enable, level_shifter_enable, aux_input_buffer_enable,
         pll_power_enable, mic_bias_enable, amplifier_bias_enable};
   endfunction
   function automatic logic [15:0] amp_st();
      return {13'h0000, bias_generator_on, bias_order_fault, output_amp_granted};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 16'h0000);
   endtask
   task automatic wr_chk(input logic [15:0] v);
      host.xfer(1'b1, ADDR_POWER_ONE, v);
      @(negedge clk);
      check(en6(), {10'h000, v[8:3]});
      check({15'h0, mic_bias_drive_en}, {15'h0, v[4]});
      rd(ADDR_POWER_ONE, {7'h00, v[8:3], REV});
   endtask
   task automatic wait_run();
      for (int i = 0; i < 40 && device_reset !== 1'b0; i++) @(negedge clk);
      check({15'h0, device_reset}, 16'h0000);
   endtask
   always @(negedge clk) begin
      if (reg_rd_valid === 1'b1) check(reg_rdata, exp_q.pop_front());
   end
   initial begin
      #(25 * 2000);
      errors++;
      end_of_test();
   end
   initial begin
      errors = 0;
      checked = 0;
      void'($urandom(5));
      rst = 1'b1;
      power_on_n = 1'b1;
      mid_rail_reference_ready = 1'b0;
      reference_buffer_ready = 1'b0;
      output_amp_request = 1'b0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      wait_run();
      check(en6(), 16'h0000);
      rd(ADDR_RESET_IDENT, ID);
      for (int i = 0; i < 12; i++) begin
         d = (i < 6) ? (16'h0008 << i) : 16'($urandom);
         wr_chk(d);
      end
      wr_chk(16'h01F8);
      host.xfer(1'b1, ADDR_RESET_IDENT, 16'($urandom));
      check({15'h0, soft_reset_strobe}, 16'h0001);
      check({15'h0, reg_wr_ack}, 16'h0001);
      @(negedge clk);
      check({15'h0, soft_reset_strobe}, 16'h0000);
      check(en6(), 16'h0000);
      wait_run();
      rd(ADDR_POWER_ONE, {13'h0, REV});
      rd(ADDR_RESET_IDENT, ID);
      host.xfer(1'b1, 7'h7F, 16'hFFFF);
      check({14'h0, reg_addr_miss, reg_wr_ack}, 16'h0003);
      rd(7'h02, 16'h0000);
      check(en6(), 16'h0000);
      output_amp_request = 1'b1;
      repeat (2) @(negedge clk);
      check(amp_st(), 16'h0002);
      wr_chk(16'h0100);
      check(amp_st(), 16'h0005);
      mid_rail_reference_ready = 1'b1;
      reference_buffer_ready = 1'b1;
      repeat (8) @(negedge clk);
      wr_chk(16'h0000);
      check(amp_st(), 16'h0005);
      output_amp_request = 1'b0;
      wr_chk(16'h01F8);
      power_on_n = 1'b0;
      repeat (10) @(negedge clk);
      check({15'h0, device_reset}, 16'h0001);
      check(en6(), 16'h0000);
      power_on_n = 1'b1;
      wait_run();
      rd(ADDR_POWER_ONE, {13'h0, REV});
      repeat (3) @(negedge clk);
      end_of_test();
   end
endmodule

// ===== src/crp_pkg.sv
// constants for the codec reset and power control register slice
package crp_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;

   // register addresses on the control port
   localparam logic [ADDR_W-1:0] ADDR_RESET_IDENT = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_POWER_ONE = 7'h01;

   // power_control_one field positions
   localparam int BIT_INDEPENDENT_BIAS = 8;
   localparam int BIT_LEVEL_SHIFTER = 7;
   localparam int BIT_AUX_INPUT_BUFFER = 6;
   localparam int BIT_PLL_POWER = 5;
   localparam int BIT_MIC_BIAS = 4;
   localparam int BIT_AMPLIFIER_BIAS = 3;
   localparam int REVISION_MSB = 2;
   localparam int REVISION_LSB = 0;
   localparam int REVISION_W = REVISION_MSB - REVISION_LSB + 1;

   // writable bits of power_control_one and their reset value
   localparam logic [DATA_W-1:0] POWER_ONE_WRITE_MASK = 16'h01F8;
   localparam logic [DATA_W-1:0] POWER_ONE_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;

   // internal reset stretch after the power-on pin releases
   localparam int CLK_PERIOD_PS = 25000;
   localparam int RESET_HOLD_NS = 100;
   localparam int RESET_HOLD_CYCLES = ((RESET_HOLD_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // reset sequencer, gray coded along reset -> hold -> run
   typedef enum logic [1:0] {
      CRP_ST_RESET = 2'b00,
      CRP_ST_HOLD = 2'b01,
      CRP_ST_RUN = 2'b11
   } crp_state_t;
endpackage

// ===== src/crp_regs.sv
// reset/identity and first power control registers of the codec
//
// How it works
// - any write to address zero in the run state soft-resets
// - address zero reads back the identity code
// - reset trigger is a strobe, not stored
// - bit 8 enables the independent bias generator
// - with reference ready bit 8 only drives independent_bias_enable
// - bit 7: level shifters, 1 normal, 0 standby
// - bit 6 switches the aux input buffer
// - bit 4 mic bias, off means high impedance
// - bit 3 enables the amplifier bias
// - bits 2:0 read revision, writes ignored
`timescale 1ns/10ps
module crp_regs
   import crp_pkg::*;
#(
   parameter logic [DATA_W-1:0] DEVICE_IDENTITY_CODE = 16'h5A01,
   parameter logic [REVISION_W-1:0] DEVICE_REVISION = 3'h1,
   parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic power_on_n,
   input wire logic mid_rail_reference_ready,
   input wire logic reference_buffer_ready,
   input wire logic output_amp_request,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rd_valid,
   output logic reg_wr_ack,
   output logic reg_addr_miss,
   output logic soft_reset_strobe,
   output logic device_reset,
   output logic independent_bias_enable,
   output logic bias_generator_on,
   output logic level_shifter_enable,
   output logic aux_input_buffer_enable,
   output logic pll_power_enable,
   output logic mic_bias_enable,
   output logic mic_bias_drive_en,
   output logic amplifier_bias_enable,
   output logic output_amp_granted,
   output logic bias_order_fault
);
   // the identity code is arbitrary; the revision value is arbitrary too

   localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

   // refuse a hold count the sequencer cannot count
   if (HOLD_CYCLES < 1) begin : g_hold_check
      $error("crp_regs: HOLD_CYCLES must be at least 1");
   end

   function automatic logic addr_is_mapped(input logic [ADDR_W-1:0] a);
      addr_is_mapped = (a == ADDR_RESET_IDENT) || (a == ADDR_POWER_ONE);
   endfunction

   // ------------------------------------------------------------------
   // pins from outside the clock domain
   logic power_on_n_s;
   logic ref_ready_s;
   logic buf_ready_s;

   crp_sync3 #(
      .WIDTH(3),
      .RESET_VAL(3'h0)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({power_on_n, mid_rail_reference_ready, reference_buffer_ready}),
      .sync_out({power_on_n_s, ref_ready_s, buf_ready_s})
   );

   // ------------------------------------------------------------------
   // reset sequencer
   crp_state_t state_ff;
   crp_state_t nxt_state;
   logic [HOLD_W-1:0] hold_cnt_ff;
   logic running;

   assign running = (state_ff == CRP_ST_RUN);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CRP_ST_RESET: begin
            if (power_on_n_s) begin
               nxt_state = CRP_ST_HOLD;
            end
         end
         CRP_ST_HOLD: begin
            if (!power_on_n_s) begin
               nxt_state = CRP_ST_RESET;
            end else if (hold_cnt_ff == HOLD_W'(HOLD_CYCLES - 1)) begin
               nxt_state = CRP_ST_RUN;
            end
         end
         CRP_ST_RUN: begin
            if (!power_on_n_s) begin
               nxt_state = CRP_ST_RESET;
            end
         end
         default: begin
            nxt_state = CRP_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= CRP_ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_ff != CRP_ST_HOLD) begin
         hold_cnt_ff <= '0;
      end else begin
         hold_cnt_ff <= hold_cnt_ff + HOLD_W'(1);
      end
   end

   // ------------------------------------------------------------------
   // access decode; accesses outside the run state are dropped
   logic wr_take;
   logic rd_take;
   logic soft_reset_hit;
   logic power_write_hit;

   assign wr_take = reg_wr && running;
   assign rd_take = reg_rd && running;
   assign soft_reset_hit = wr_take && (reg_addr == ADDR_RESET_IDENT);
   assign power_write_hit = wr_take && (reg_addr == ADDR_POWER_ONE);

   logic soft_reset_strobe_ff;
   logic device_reset_ff;

   // reset trigger is a pure pulse and keeps nothing to read back
   always_ff @(posedge clk) begin
      if (rst) begin
         soft_reset_strobe_ff <= 1'b0;
      end else begin
         soft_reset_strobe_ff <= soft_reset_hit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         device_reset_ff <= 1'b1;
      end else begin
         device_reset_ff <= (nxt_state != CRP_ST_RUN) || soft_reset_hit;
      end
   end

   // ------------------------------------------------------------------
   // power_control_one storage; only bits 8:3 hold state
   logic [DATA_W-1:0] power_one_ff;

   always_ff @(posedge clk) begin
      if (rst || !running || soft_reset_hit) begin
         power_one_ff <= POWER_ONE_RESET;
      end else if (power_write_hit) begin
         // reserved and revision bits never take written data
         power_one_ff <= reg_wdata & POWER_ONE_WRITE_MASK;
      end
   end

   // ------------------------------------------------------------------
   // read path
   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] reg_rdata_ff;
   logic reg_rd_valid_ff;
   logic reg_wr_ack_ff;
   logic reg_addr_miss_ff;

   always_comb begin
      nxt_rdata = READ_UNMAPPED;
      if (reg_addr == ADDR_RESET_IDENT) begin
         nxt_rdata = DEVICE_IDENTITY_CODE;
      end else if (reg_addr == ADDR_POWER_ONE) begin
         nxt_rdata = power_one_ff & POWER_ONE_WRITE_MASK;
         nxt_rdata[REVISION_MSB:REVISION_LSB] = DEVICE_REVISION;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata_ff <= READ_UNMAPPED;
      end else if (rd_take) begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rd_valid_ff <= 1'b0;
         reg_wr_ack_ff <= 1'b0;
         reg_addr_miss_ff <= 1'b0;
      end else begin
         reg_rd_valid_ff <= rd_take;
         reg_wr_ack_ff <= wr_take;
         reg_addr_miss_ff <= (wr_take || rd_take) && !addr_is_mapped(reg_addr);
      end
   end

   // ------------------------------------------------------------------
   // power enables toward the analogue blocks
   logic ind_bias_bit;
   logic ref_active;
   logic bias_on;
   logic independent_bias_enable_ff;
   logic bias_generator_on_ff;
   logic level_shifter_enable_ff;
   logic aux_input_buffer_enable_ff;
   logic pll_power_enable_ff;
   logic mic_bias_enable_ff;
   logic mic_bias_drive_en_ff;
   logic amplifier_bias_enable_ff;
   logic output_amp_granted_ff;
   logic bias_order_fault_ff;

   assign ind_bias_bit = power_one_ff[BIT_INDEPENDENT_BIAS];
   assign ref_active = ref_ready_s && buf_ready_s;
   // bias comes either from bit 8 or from a ready reference
   assign bias_on = ind_bias_bit || ref_active;

   always_ff @(posedge clk) begin
      if (rst) begin
         independent_bias_enable_ff <= 1'b0;
         bias_generator_on_ff <= 1'b0;
      end else begin
         independent_bias_enable_ff <= ind_bias_bit;
         bias_generator_on_ff <= bias_on;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         level_shifter_enable_ff <= 1'b0;
         aux_input_buffer_enable_ff <= 1'b0;
         pll_power_enable_ff <= 1'b0;
      end else begin
         level_shifter_enable_ff <= power_one_ff[BIT_LEVEL_SHIFTER];
         aux_input_buffer_enable_ff <= power_one_ff[BIT_AUX_INPUT_BUFFER];
         pll_power_enable_ff <= power_one_ff[BIT_PLL_POWER];
      end
   end

   // mic bias output is released to high impedance when off
   always_ff @(posedge clk) begin
      if (rst) begin
         mic_bias_enable_ff <= 1'b0;
         mic_bias_drive_en_ff <= 1'b0;
      end else begin
         mic_bias_enable_ff <= power_one_ff[BIT_MIC_BIAS];
         mic_bias_drive_en_ff <= power_one_ff[BIT_MIC_BIAS];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         amplifier_bias_enable_ff <= 1'b0;
      end else begin
         amplifier_bias_enable_ff <= power_one_ff[BIT_AMPLIFIER_BIAS];
      end
   end

   // amplifiers only start once some bias source is up; the fault flags
   // a request made before the reference without bit 8 set
   always_ff @(posedge clk) begin
      if (rst || !running) begin
         output_amp_granted_ff <= 1'b0;
         bias_order_fault_ff <= 1'b0;
      end else begin
         output_amp_granted_ff <= output_amp_request && bias_on;
         bias_order_fault_ff <= output_amp_request && !ref_active && !ind_bias_bit;
      end
   end

   assign reg_rdata = reg_rdata_ff;
   assign reg_rd_valid = reg_rd_valid_ff;
   assign reg_wr_ack = reg_wr_ack_ff;
   assign reg_addr_miss = reg_addr_miss_ff;
   assign soft_reset_strobe = soft_reset_strobe_ff;
   assign device_reset = device_reset_ff;
   assign independent_bias_enable = independent_bias_enable_ff;
   assign bias_generator_on = bias_generator_on_ff;
   assign level_shifter_enable = level_shifter_enable_ff;
   assign aux_input_buffer_enable = aux_input_buffer_enable_ff;
   assign pll_power_enable = pll_power_enable_ff;
   assign mic_bias_enable = mic_bias_enable_ff;
   assign mic_bias_drive_en = mic_bias_drive_en_ff;
   assign amplifier_bias_enable = amplifier_bias_enable_ff;
   assign output_amp_granted = output_amp_granted_ff;
   assign bias_order_fault = bias_order_fault_ff;
endmodule

// ===== src/crp_sync3.sv
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/10ps
module crp_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] stage3_ff;
   logic [WIDTH-1:0] out_ff;

   if (WIDTH < 1) begin : g_width_check
      $error("crp_sync3: WIDTH must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1_ff <= RESET_VAL;
         stage2_ff <= RESET_VAL;
         stage3_ff <= RESET_VAL;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
      end
   end

   // a bit only changes once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge clk) begin
            if (rst) begin
               out_ff[gi] <= RESET_VAL[gi];
            end else if (stage2_ff[gi] == stage3_ff[gi]) begin
               out_ff[gi] <= stage3_ff[gi];
            end
         end
      end
   endgenerate

   assign sync_out = out_ff;
endmodule
